// ===== logic/mbs_server.sv
// Modbus/TCP request server: frame parsing, read decode and response build
//
// Contract
// - Frames arrive on a TCP connection to server port 502, shown on srv_port.
// - Every multi-byte field but the float value is sent and taken most significant byte first.
// - Only the header length bytes decide where a request ends.
// - Response carries the request transaction identifier unchanged.
// - Length field counts unit byte plus all PDU bytes after it.
// - Function 0x01 reads 1 to 2000 bits; other quantities are rejected.
// - Bit addresses are zero-based; sent address is used as is.
// - Each returned bit is one for ON, zero for OFF.
// - First bit lands in LSB of first byte, filling upward through bytes.
// - Unused high bits of the last bit byte are zeros.
// - Bit response byte count is quantity divided by eight, rounded up.
// - Failure reply is function code plus 0x80 and one exception byte.
// - Function 0x03 returns 32-bit floating-point values.
// - Function 0x03 quantity counts halves, 2 to 124, four bytes per float.
// - Float response byte count is twice the requested quantity.
// - Each float sends low half first, each half high byte first.
// - Float register addresses are zero-based.
// - Function 0x04 reads 1 to 125 input registers, zero-based.
// - Each input register is two bytes high first; count twice quantity.
`timescale 1ns/10ps
`include "mbs_regs.svh"

module mbs_server (
  input logic core_clk, // 20 MHz clock
  input logic nrst, // Asynchronous reset, active low
  input logic rx_valid, // Request byte present
  input logic [7:0] rx_data, // Request byte
  output logic rx_ready, // Request byte taken when valid
  output mbs_pkg::mbs_tx_t tx, // Response byte stream
  input logic tx_ready, // Response byte taken when valid
  output mbs_pkg::mbs_rd_t rd, // Table read request
  input mbs_pkg::mbs_rd_data_t rd_data, // Table read answer, in the strobe cycle
  output logic [15:0] srv_port // Server TCP port
);
  import mbs_pkg::*;

  // =====================================================
  // State and storage
  mbs_state_t state_r;
  mbs_state_t state_nxt;
  logic rx_ready_r;
  mbs_tx_t tx_r;
  mbs_rd_t rd_r;
  logic [15:0] srv_port_r;
  logic [2:0] hdr_idx_r;
  logic [15:0] pdu_idx_r;
  logic [15:0] tid_r;
  logic [15:0] len_r;
  logic [7:0] unit_r;
  mbs_req_t req_r;
  logic [7:0] exc_r;
  logic [7:0] bc_r;
  logic [15:0] rsp_len_r;
  logic [3:0] txp_r;
  logic [7:0] byte_idx_r;
  logic [2:0] bit_n_r;
  logic [7:0] pack_r;
  logic [15:0] word_r;

  // Combinational helpers
  logic rx_take;
  logic tx_done;
  logic [15:0] pdu_len;
  logic hdr_end;
  logic pdu_end;
  logic [7:0] exc_code;
  logic [7:0] byte_cnt;
  logic [15:0] rsp_len;
  logic [15:0] bit_pos;
  logic bit_in_range;
  logic data_last;
  logic [7:0] hdr_byte;
  logic [7:0] data_byte;

  // =====================================================
  // Handshakes and frame extent
  assign rx_take = rx_valid && rx_ready_r;
  assign tx_done = tx_r.valid && tx_ready;
  assign pdu_len = (len_r > `MBS_UNIT_BYTES) ? len_r - `MBS_UNIT_BYTES : '0;
  assign hdr_end = rx_take && (state_r == MBS_RX_HDR) && (hdr_idx_r == `MBS_RXH_UNIT);
  assign pdu_end = rx_take && (state_r == MBS_RX_PDU) && (pdu_idx_r == pdu_len - `MBS_UNIT_BYTES);
  assign bit_pos = {5'h00, byte_idx_r, bit_n_r};
  assign bit_in_range = bit_pos < req_r.qty;
  assign data_last = byte_idx_r == bc_r - 8'h01;

  // Request validation and sizing
  mbs_req_check u_check (
    .req(req_r),
    .pdu_len(pdu_len),
    .exc_code(exc_code),
    .byte_cnt(byte_cnt),
    .rsp_len(rsp_len)
  );

  // =====================================================
  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      MBS_RX_HDR: begin
        if (hdr_end) begin
          state_nxt = (len_r > `MBS_UNIT_BYTES) ? MBS_RX_PDU : MBS_CHECK;
        end
      end
      MBS_RX_PDU: begin
        if (pdu_end) begin
          state_nxt = MBS_CHECK;
        end
      end
      MBS_CHECK: begin
        state_nxt = MBS_TX_HDR;
      end
      MBS_TX_HDR: begin
        if (tx_done && txp_r == `MBS_TXP_LAST) begin
          state_nxt = (exc_r != `MBS_EXC_OK) ? MBS_RX_HDR : MBS_FETCH;
        end
      end
      MBS_FETCH: begin
        if (req_r.fc != `MBS_FC_BITS && byte_idx_r[0]) begin
          state_nxt = MBS_TX_DATA;
        end else begin
          state_nxt = MBS_LATCH;
        end
      end
      MBS_LATCH: begin
        if (req_r.fc == `MBS_FC_BITS && bit_n_r != `MBS_BIT_LAST) begin
          state_nxt = MBS_FETCH;
        end else begin
          state_nxt = MBS_TX_DATA;
        end
      end
      MBS_TX_DATA: begin
        if (tx_done) begin
          state_nxt = data_last ? MBS_RX_HDR : MBS_FETCH;
        end
      end
    endcase
  end

  // Sequencer state register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= MBS_RX_HDR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =====================================================
  // Request byte acceptance: held high while a frame is being read
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rx_ready_r <= 1'b0;
    end else begin
      rx_ready_r <= (state_nxt == MBS_RX_HDR) || (state_nxt == MBS_RX_PDU);
    end
  end

  // Header capture: identifier, length and unit; protocol bytes are not decoded
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      hdr_idx_r <= '0;
      tid_r <= '0;
      len_r <= '0;
      unit_r <= '0;
    end else if (rx_take && state_r == MBS_RX_HDR) begin
      hdr_idx_r <= hdr_end ? '0 : hdr_idx_r + 3'h1;
      unique case (hdr_idx_r)
        `MBS_RXH_TID_HI: tid_r[15:8] <= rx_data;
        `MBS_RXH_TID_LO: tid_r[7:0] <= rx_data;
        `MBS_RXH_LEN_HI: len_r[15:8] <= rx_data;
        `MBS_RXH_LEN_LO: len_r[7:0] <= rx_data;
        `MBS_RXH_UNIT: unit_r <= rx_data;
        default: begin
        end
      endcase
    end
  end

  // PDU capture: function, start and quantity, surplus bytes discarded
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pdu_idx_r <= '0;
      req_r <= '0;
    end else if (hdr_end) begin
      pdu_idx_r <= '0;
      req_r <= '0;
    end else if (rx_take && state_r == MBS_RX_PDU) begin
      pdu_idx_r <= pdu_idx_r + `MBS_UNIT_BYTES;
      unique case (pdu_idx_r)
        `MBS_PDU_FC: req_r.fc <= rx_data;
        `MBS_PDU_ADR_HI: req_r.start[15:8] <= rx_data;
        `MBS_PDU_ADR_LO: req_r.start[7:0] <= rx_data;
        `MBS_PDU_QTY_HI: req_r.qty[15:8] <= rx_data;
        `MBS_PDU_QTY_LO: req_r.qty[7:0] <= rx_data;
        default: begin
        end
      endcase
    end
  end

  // Verdict and sizes frozen for the whole response
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      exc_r <= '0;
      bc_r <= '0;
      rsp_len_r <= '0;
    end else if (state_r == MBS_CHECK) begin
      exc_r <= exc_code;
      bc_r <= byte_cnt;
      rsp_len_r <= rsp_len;
    end
  end

  // =====================================================
  // Response header bytes, identifier echoed
  always_comb begin
    hdr_byte = `MBS_PROTO_ID;
    unique case (txp_r)
      `MBS_TXP_TID_HI: hdr_byte = tid_r[15:8];
      `MBS_TXP_TID_LO: hdr_byte = tid_r[7:0];
      `MBS_TXP_PRO_HI: hdr_byte = `MBS_PROTO_ID;
      `MBS_TXP_PRO_LO: hdr_byte = `MBS_PROTO_ID;
      `MBS_TXP_LEN_HI: hdr_byte = rsp_len_r[15:8];
      `MBS_TXP_LEN_LO: hdr_byte = rsp_len_r[7:0];
      `MBS_TXP_UNIT: hdr_byte = unit_r;
      `MBS_TXP_FC: hdr_byte = (exc_r != `MBS_EXC_OK) ? (req_r.fc | `MBS_EXC_FLAG) : req_r.fc;
      `MBS_TXP_LAST: hdr_byte = (exc_r != `MBS_EXC_OK) ? exc_r : bc_r;
      default: hdr_byte = `MBS_PROTO_ID;
    endcase
  end

  // Data byte: packed bits, or the selected half high byte first
  always_comb begin
    data_byte = byte_idx_r[0] ? word_r[7:0] : word_r[15:8];
    if (req_r.fc == `MBS_FC_BITS) begin
      data_byte = pack_r;
    end
  end

  // Header position counter
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txp_r <= '0;
    end else if (state_r == MBS_CHECK) begin
      txp_r <= '0;
    end else if (tx_done && state_r == MBS_TX_HDR) begin
      txp_r <= txp_r + `MBS_TXP_STEP;
    end
  end

  // Response byte register: loaded when idle, cleared once taken
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tx_r <= '0;
    end else if (tx_done) begin
      tx_r <= '0;
    end else if (!tx_r.valid && state_r == MBS_TX_HDR) begin
      tx_r.valid <= 1'b1;
      tx_r.last <= (txp_r == `MBS_TXP_LAST) && (exc_r != `MBS_EXC_OK);
      tx_r.data <= hdr_byte;
    end else if (!tx_r.valid && state_r == MBS_TX_DATA) begin
      tx_r.valid <= 1'b1;
      tx_r.last <= data_last;
      tx_r.data <= data_byte;
    end
  end

  // =====================================================
  // Data byte and bit counters
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      byte_idx_r <= '0;
      bit_n_r <= '0;
    end else if (state_r == MBS_CHECK) begin
      byte_idx_r <= '0;
      bit_n_r <= '0;
    end else if (state_r == MBS_LATCH && req_r.fc == `MBS_FC_BITS && bit_n_r != `MBS_BIT_LAST) begin
      bit_n_r <= bit_n_r + 3'h1;
    end else if (tx_done && state_r == MBS_TX_DATA) begin
      byte_idx_r <= byte_idx_r + 8'h01;
      bit_n_r <= '0;
    end
  end

  // Table read request: one strobe per in-range bit, per float half, per input register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_r <= '0;
    end else if (state_r == MBS_FETCH) begin
      rd_r.strobe <= 1'b0;
      if (req_r.fc == `MBS_FC_BITS) begin
        rd_r.strobe <= bit_in_range;
        rd_r.sel <= MBS_SEL_BIT;
        rd_r.addr <= req_r.start + bit_pos;
      end else if (req_r.fc == `MBS_FC_FLOAT && !byte_idx_r[0]) begin
        rd_r.strobe <= 1'b1;
        rd_r.sel <= MBS_SEL_FLOAT;
        rd_r.addr <= req_r.start + {9'h000, byte_idx_r[7:2], 1'b0};
      end else if (!byte_idx_r[0]) begin
        rd_r.strobe <= 1'b1;
        rd_r.sel <= MBS_SEL_INREG;
        rd_r.addr <= req_r.start + {8'h00, 1'b0, byte_idx_r[7:1]};
      end
    end else begin
      rd_r.strobe <= 1'b0;
    end
  end

  // Bit packing: in-range bits as read, padding as zero
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pack_r <= '0;
    end else if (tx_done && state_r == MBS_TX_DATA) begin
      pack_r <= '0;
    end else if (state_r == MBS_LATCH && req_r.fc == `MBS_FC_BITS) begin
      pack_r[bit_n_r] <= bit_in_range && rd_data.bit_status;
    end
  end

  // Word capture: float halves low first, or the input register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      word_r <= '0;
    end else if (state_r == MBS_LATCH && req_r.fc == `MBS_FC_FLOAT) begin
      word_r <= byte_idx_r[1] ? rd_data.float_value[31:16] : rd_data.float_value[15:0];
    end else if (state_r == MBS_LATCH && req_r.fc == `MBS_FC_INREG) begin
      word_r <= rd_data.inreg_value;
    end
  end

  // Server port value
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      srv_port_r <= `MBS_TCP_PORT;
    end else begin
      srv_port_r <= `MBS_TCP_PORT;
    end
  end

  // =====================================================
  // Outputs
  assign rx_ready = rx_ready_r;
  assign tx = tx_r;
  assign rd = rd_r;
  assign srv_port = srv_port_r;

endmodule : mbs_server

// ===== logic/mbs_regs.svh
// Constants for the request server: protocol codes, limits and frame positions
`ifndef MBS_REGS_SVH
`define MBS_REGS_SVH

// =====================================================
// Transport and protocol values
`define MBS_TCP_PORT 16'h01f6
`define MBS_PROTO_ID 8'h00

// =====================================================
// Function codes and exception codes
`define MBS_FC_BITS 8'h01
`define MBS_FC_FLOAT 8'h03
`define MBS_FC_INREG 8'h04
`define MBS_FC_NONE 8'h00
`define MBS_EXC_FLAG 8'h80
`define MBS_EXC_OK 8'h00
`define MBS_EXC_FUNC 8'h01
`define MBS_EXC_VALUE 8'h03

// =====================================================
// Quantity limits per function
`define MBS_BITS_MIN 16'h0001
`define MBS_BITS_MAX 16'h07d0
`define MBS_FLOAT_MIN 16'h0002
`define MBS_FLOAT_MAX 16'h007c
`define MBS_INREG_MIN 16'h0001
`define MBS_INREG_MAX 16'h007d
`define MBS_BITS_ROUND 16'h0007

// =====================================================
// Request header byte positions (seven-byte header)
`define MBS_RXH_TID_HI 3'h0
`define MBS_RXH_TID_LO 3'h1
`define MBS_RXH_LEN_HI 3'h4
`define MBS_RXH_LEN_LO 3'h5
`define MBS_RXH_UNIT 3'h6

// =====================================================
// Request PDU byte positions and sizes
`define MBS_PDU_FC 16'h0000
`define MBS_PDU_ADR_HI 16'h0001
`define MBS_PDU_ADR_LO 16'h0002
`define MBS_PDU_QTY_HI 16'h0003
`define MBS_PDU_QTY_LO 16'h0004
`define MBS_PDU_FIXED 16'h0005
`define MBS_UNIT_BYTES 16'h0001

// =====================================================
// Response header byte positions
`define MBS_TXP_TID_HI 4'h0
`define MBS_TXP_TID_LO 4'h1
`define MBS_TXP_PRO_HI 4'h2
`define MBS_TXP_PRO_LO 4'h3
`define MBS_TXP_LEN_HI 4'h4
`define MBS_TXP_LEN_LO 4'h5
`define MBS_TXP_UNIT 4'h6
`define MBS_TXP_FC 4'h7
`define MBS_TXP_LAST 4'h8
`define MBS_TXP_STEP 4'h1
`define MBS_RSP_FIXED 16'h0003
`define MBS_BIT_LAST 3'h7

`endif

// ===== logic/mbs_pkg.sv
// Types shared by the request server modules
package mbs_pkg;

  // =====================================================
  // Sequencer states
  typedef enum logic [2:0] {
    MBS_RX_HDR,
    MBS_RX_PDU,
    MBS_CHECK,
    MBS_TX_HDR,
    MBS_FETCH,
    MBS_LATCH,
    MBS_TX_DATA
  } mbs_state_t;

  // Data source selector for a table read
  typedef enum logic [1:0] {
    MBS_SEL_NONE,
    MBS_SEL_BIT,
    MBS_SEL_FLOAT,
    MBS_SEL_INREG
  } mbs_sel_t;

  // Decoded request fields
  typedef struct packed {
    logic [7:0] fc;
    logic [15:0] start;
    logic [15:0] qty;
  } mbs_req_t;

  // Outgoing byte stream
  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } mbs_tx_t;

  // Table read request
  typedef struct packed {
    logic strobe;
    mbs_sel_t sel;
    logic [15:0] addr;
  } mbs_rd_t;

  // Table read answer
  typedef struct packed {
    logic bit_status;
    logic [31:0] float_value;
    logic [15:0] inreg_value;
  } mbs_rd_data_t;

endpackage : mbs_pkg

// ===== logic/mbs_req_check.sv
// Request validation and response sizing
`timescale 1ns/10ps
`include "mbs_regs.svh"

module mbs_req_check (
  input mbs_pkg::mbs_req_t req, // Decoded request fields
  input logic [15:0] pdu_len, // PDU bytes received
  output logic [7:0] exc_code, // Exception code, zero when good
  output logic [7:0] byte_cnt, // Response data byte count
  output logic [15:0] rsp_len // Response header length field
);
  import mbs_pkg::*;

  logic [15:0] bit_bytes;
  logic [15:0] word_bytes;

  // Byte counts for the three read kinds
  assign bit_bytes = (req.qty + `MBS_BITS_ROUND) >> 3;
  assign word_bytes = {req.qty[14:0], 1'b0};

  // Function check first, then quantity range, then PDU size
  always_comb begin
    exc_code = `MBS_EXC_OK;
    byte_cnt = '0;
    unique case (req.fc)
      `MBS_FC_BITS: begin
        byte_cnt = bit_bytes[7:0];
        if (req.qty < `MBS_BITS_MIN || req.qty > `MBS_BITS_MAX) begin
          exc_code = `MBS_EXC_VALUE;
        end
      end
      `MBS_FC_FLOAT: begin
        byte_cnt = word_bytes[7:0];
        if (req.qty < `MBS_FLOAT_MIN || req.qty > `MBS_FLOAT_MAX) begin
          exc_code = `MBS_EXC_VALUE;
        end
      end
      `MBS_FC_INREG: begin
        byte_cnt = word_bytes[7:0];
        if (req.qty < `MBS_INREG_MIN || req.qty > `MBS_INREG_MAX) begin
          exc_code = `MBS_EXC_VALUE;
        end
      end
      default: begin
        exc_code = `MBS_EXC_FUNC;
      end
    endcase
    if (exc_code == `MBS_EXC_OK && pdu_len < `MBS_PDU_FIXED) begin
      exc_code = `MBS_EXC_VALUE;
    end
  end

  // Length counts unit byte, function code and all bytes after
  assign rsp_len = (exc_code != `MBS_EXC_OK) ? `MBS_RSP_FIXED - `MBS_UNIT_BYTES + `MBS_UNIT_BYTES
                                             : `MBS_RSP_FIXED + {8'h00, byte_cnt};

endmodule : mbs_req_check

// ===== tb/mbs_table_model.sv
// Data table model answering the server's table reads
`timescale 1ns/10ps
module mbs_table_model (
  input mbs_pkg::mbs_rd_t rd, // Table read request
  output mbs_pkg::mbs_rd_data_t rd_data // Table read answer
);
  import mbs_pkg::*;
  logic [15:0] a;
  logic v;
  assign a = rd.addr;
  assign v = rd.strobe;
  // Answer is good only in the strobe cycle; otherwise inverted to expose late sampling
  always_comb begin
    rd_data.bit_status = a[0] ^ a[2] ^ !v;
    rd_data.float_value = {~a, a} ^ {32{!v}};
    rd_data.inreg_value = a ^ 16'h5a5a ^ {16{!v}};
  end
endmodule : mbs_table_model

// ===== tb/mbs_server_sva.sv
// Checker for the request server response stream and table reads
`timescale 1ns/10ps
module mbs_server_sva (
  input logic core_clk, // Clock
  input logic nrst, // Reset, active low
  input logic rx_valid, // Request byte present
  input logic [7:0] rx_data, // Request byte
  input logic rx_ready, // Request byte taken
  input mbs_pkg::mbs_tx_t tx, // Response stream
  input logic tx_ready, // Response byte taken
  input mbs_pkg::mbs_rd_t rd, // Table read request
  input mbs_pkg::mbs_rd_data_t rd_data, // Table read answer
  input logic [15:0] srv_port // Server port
);
  import mbs_pkg::*;
  logic acc;
  logic [8:0] idx_r;
  logic [7:0] len_r;
  logic [7:0] fc_r;
  // =====================================================
  // Response byte position and captured header fields
  assign acc = tx.valid && tx_ready;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      idx_r <= 9'h000;
    end else if (acc) begin
      idx_r <= tx.last ? 9'h000 : idx_r + 9'h001;
    end
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      len_r <= 8'h00;
      fc_r <= 8'h00;
    end else if (acc && idx_r == 9'h005) begin
      len_r <= tx.data;
    end else if (acc && idx_r == 9'h007) begin
      fc_r <= tx.data;
    end
  end
  // =====================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_exc_fc;
    acc && idx_r == 9'h007 && tx.data[7];
  endsequence
  sequence s_exc_code;
    acc && tx.last && tx.data >= 8'h01 && tx.data <= 8'h04;
  endsequence
  chk_port_fixed: assert property (srv_port == 16'h01f6)
    else $error("server port wrong");
  chk_tx_hold: assert property (tx.valid && !tx_ready |=> tx.valid && $stable(tx.data) && $stable(tx.last))
    else $error("response byte changed before taken");
  chk_tx_gap: assert property (acc |=> !tx.valid)
    else $error("response byte not released after taken");
  chk_rx_quiet: assert property (tx.valid |-> !rx_ready)
    else $error("request taken while responding");
  chk_rx_resume: assert property (acc && tx.last |-> ##[1:2] rx_ready)
    else $error("request side not reopened");
  chk_proto_zero: assert property (acc && (idx_r == 9'h002 || idx_r == 9'h003) |-> tx.data == 8'h00)
    else $error("protocol id not zero");
  chk_len_total: assert property (acc && tx.last |-> idx_r == {1'b0, len_r} + 9'h005)
    else $error("length field disagrees with bytes sent");
  chk_exc_reply: assert property (s_exc_fc |-> len_r == 8'h03 ##[1:20] s_exc_code)
    else $error("bad exception reply");
  chk_byte_count: assert property (acc && idx_r == 9'h008 && !fc_r[7] |-> tx.data == len_r - 8'h03)
    else $error("byte count disagrees with length");
  chk_strobe_pulse: assert property (rd.strobe |-> rd.sel != MBS_SEL_NONE ##1 !rd.strobe)
    else $error("bad table read strobe");
endmodule : mbs_server_sva

bind mbs_server mbs_server_sva i_sva (.core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid),
  .rx_data(rx_data), .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .rd(rd), .rd_data(rd_data),
  .srv_port(srv_port));

// ===== tb/mbs_server_tb.sv
// Self-checking bench for the request server
`timescale 1ns/10ps
module mbs_server_tb;
  import mbs_pkg::*;
  localparam int DLY = 2;
  logic core_clk, nrst, rx_valid, rx_ready, tx_ready;
  logic [7:0] rx_data, seq;
  logic [15:0] srv_port;
  mbs_tx_t tx;
  mbs_rd_t rd;
  mbs_rd_data_t rd_data;
  int n_errors, total_checks, stall;

  mbs_server i_dut (.core_clk(core_clk), .nrst(nrst), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx(tx), .tx_ready(tx_ready), .rd(rd), .rd_data(rd_data), .srv_port(srv_port));
  mbs_table_model i_table (.rd(rd), .rd_data(rd_data));

  // Clock, 50 ns period
  always #25 core_clk = ~core_clk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // Offer one request byte and hold it until taken
  task automatic send_byte(input logic [7:0] b);
    int t;
    t = 0;
    rx_valid = 1'b1;
    rx_data = b;
    do begin
      @(posedge core_clk);
      t++;
    end while (rx_ready !== 1'b1 && t < 200);
    if (t >= 200) check("rx_wait", 16'h0000, 16'h0001);
    #DLY;
  endtask : send_byte

  // Take one response byte, optionally stalling first
  task automatic get_byte(output logic [7:0] b, output logic l);
    int t;
    t = 0;
    do begin
      @(posedge core_clk);
      t++;
    end while (tx.valid !== 1'b1 && t < 200);
    if (stall > 0) begin
      repeat (stall) @(posedge core_clk);
      #DLY;
      tx_ready = 1'b1;
      @(posedge core_clk);
    end
    b = tx.data;
    l = tx.last;
    #DLY;
    if (stall > 0) tx_ready = 1'b0;
    if (t >= 200) check("tx_wait", 16'h0000, 16'h0001);
  endtask : get_byte

  // One request out, the whole response built from the protocol and compared
  task automatic xact(input logic [7:0] fc, input logic [15:0] st, qty, len);
    logic [7:0] q[$], p[$], b, efc, code, bc;
    logic [31:0] f;
    logic [15:0] h, a, tid;
    logic l;
    int n;
    seq++;
    tid = {seq, 8'hc3};
    p = '{fc, st[15:8], st[7:0], qty[15:8], qty[7:0], 8'h77, 8'h77, 8'h77};
    efc = (len > 16'h0001) ? fc : 8'h00;
    code = 8'h00;
    if (efc != 8'h01 && efc != 8'h03 && efc != 8'h04) code = 8'h01;
    else if (len < 16'h0006) code = 8'h03;
    else if (efc == 8'h01 && (qty < 16'h0001 || qty > 16'h07d0)) code = 8'h03;
    else if (efc == 8'h03 && (qty < 16'h0002 || qty > 16'h007c)) code = 8'h03;
    else if (efc == 8'h04 && (qty < 16'h0001 || qty > 16'h007d)) code = 8'h03;
    bc = (efc == 8'h01) ? 8'((qty + 16'h0007) >> 3) : 8'(qty << 1);
    q = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, (code != 8'h00) ? 8'h03 : 8'h03 + bc, seq ^ 8'h5a};
    if (code != 8'h00) begin
      q.push_back(efc | 8'h80);
      q.push_back(code);
    end else begin
      q.push_back(efc);
      q.push_back(bc);
      for (int j = 0; j < bc; j++) begin
        b = 8'h00;
        if (efc == 8'h01) begin
          for (int k = 0; k < 8; k++) begin
            n = 8 * j + k;
            a = 16'(st + n);
            if (n < qty) b[k] = a[0] ^ a[2];
          end
        end else if (efc == 8'h03) begin
          a = 16'(st + 2 * (j >> 2));
          f = {~a, a};
          h = j[1] ? f[31:16] : f[15:0];
          b = j[0] ? h[7:0] : h[15:8];
        end else begin
          h = 16'(st + (j >> 1)) ^ 16'h5a5a;
          b = j[0] ? h[7:0] : h[15:8];
        end
        q.push_back(b);
      end
    end
    send_byte(tid[15:8]);
    send_byte(tid[7:0]);
    send_byte(8'hff);
    send_byte(8'h00);
    send_byte(len[15:8]);
    send_byte(len[7:0]);
    send_byte(seq ^ 8'h5a);
    for (int i = 0; i + 1 < len; i++) send_byte(p[i]);
    rx_valid = 1'b0;
    foreach (q[i]) begin
      get_byte(b, l);
      check("rsp_byte", 16'(b), 16'(q[i]));
      check("rsp_last", 16'(l), 16'(i == q.size() - 1));
    end
  endtask : xact

  task automatic t_reset;
    check("srv_port", srv_port, 16'h01f6);
    check("rx_ready", 16'(rx_ready), 16'h0000);
    check("tx", 16'(tx), 16'h0000);
    check("rd_strobe", 16'(rd.strobe), 16'h0000);
    check("rd_addr", rd.addr, 16'h0000);
  endtask : t_reset

  task automatic t_bits;
    xact(8'h01, 16'h0000, 16'h0001, 16'h0006);
    xact(8'h01, 16'h0013, 16'h0013, 16'h0006);
    xact(8'h01, 16'h0005, 16'h07d0, 16'h0006);
    xact(8'h01, 16'h0000, 16'h0000, 16'h0006);
    xact(8'h01, 16'h0000, 16'h07d1, 16'h0006);
  endtask : t_bits

  task automatic t_float;
    xact(8'h03, 16'h0000, 16'h0002, 16'h0006);
    xact(8'h03, 16'h9d09, 16'h0006, 16'h0006);
    xact(8'h03, 16'h0028, 16'h0003, 16'h0006);
    xact(8'h03, 16'h0064, 16'h007c, 16'h0006);
    xact(8'h03, 16'h0000, 16'h0001, 16'h0006);
    xact(8'h03, 16'h0000, 16'h007d, 16'h0006);
  endtask : t_float

  task automatic t_inreg;
    xact(8'h04, 16'h0008, 16'h0001, 16'h0006);
    xact(8'h04, 16'h0000, 16'h007d, 16'h0006);
    xact(8'h04, 16'h0000, 16'h0000, 16'h0006);
    xact(8'h04, 16'h0000, 16'h007e, 16'h0006);
  endtask : t_inreg

  task automatic t_errors;
    xact(8'h05, 16'h0000, 16'h0001, 16'h0006);
    xact(8'h01, 16'h0000, 16'h0001, 16'h0001);
    xact(8'h01, 16'h0000, 16'h0008, 16'h0004);
    xact(8'h01, 16'h0002, 16'h0009, 16'h0009);
  endtask : t_errors

  // Response side holds off each byte for a few cycles
  task automatic t_stall;
    stall = 3;
    tx_ready = 1'b0;
    xact(8'h04, 16'h0003, 16'h0002, 16'h0006);
    @(posedge core_clk);
    #DLY;
    stall = 0;
    tx_ready = 1'b1;
  endtask : t_stall

  // Reset in the middle of a header, then a clean request must parse from byte zero
  task automatic t_rerun;
    for (int i = 0; i < 4; i++) send_byte(8'h00);
    rx_valid = 1'b0;
    nrst = 1'b0;
    @(posedge core_clk);
    #DLY;
    t_reset;
    nrst = 1'b1;
    @(posedge core_clk);
    #DLY;
    xact(8'h04, 16'h0001, 16'h0002, 16'h0006);
  endtask : t_rerun

  initial begin
    core_clk = 1'b0;
    nrst = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b1;
    stall = 0;
    seq = 8'h00;
    repeat (4) @(posedge core_clk);
    #DLY;
    t_reset;
    nrst = 1'b1;
    @(posedge core_clk);
    #DLY;
    t_bits;
    t_float;
    t_inreg;
    t_errors;
    t_stall;
    t_rerun;
    wrap_up;
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge core_clk);
    n_errors++;
    wrap_up;
  end
endmodule : mbs_server_tb
